// ### hdl/pbl_pin_cell.sv
// Package of constants and the single-line pin cell for the low port lines
package pbl_pkg;
  localparam int unsigned PBL_LINES = 5;
  localparam int unsigned PBL_ADDR_W = 8;
  localparam int unsigned PBL_DATA_W = 32;
  localparam int unsigned PBL_CMP_LINE = 4;
  localparam logic [7:0] PBL_OFF_DATA = 8'h00;
  localparam logic [7:0] PBL_OFF_DIR = 8'h04;
  localparam logic [7:0] PBL_OFF_PDI = 8'h08;
  localparam logic [4:0] PBL_RST_DATA = 5'h00;
  localparam logic [4:0] PBL_RST_DIR = 5'h00;
  localparam logic [4:0] PBL_RST_PDI = 5'h00;
  localparam logic [31:0] PBL_ZERO_WORD = 32'h00000000;
endpackage

`timescale 1ns/10ps

// One port line: output drive, pulldown control and read-back selection
module pbl_pin_cell (
  input wire logic drive_value, // Value to put on the pin when driven
  input wire logic dir_bit_n, // Direction bit, 1 selects output
  input wire logic pulldown_inhibit_n, // Software pulldown inhibit bit
  input wire logic mask_pd_inhibit, // Mask option disabling all pulldowns
  input wire logic pin_in, // Pin level after the digital threshold
  output logic pin_out, // Pin output value
  output logic pin_oe, // Pin output enable, high while driving
  output logic pulldown_en, // Pulldown switched on
  output logic read_value // Value returned by a data read
);
  // Output buffer follows the direction bit alone
  always_comb begin
    pin_out = drive_value;
    pin_oe = dir_bit_n;
    // Pulldown only for an input with both inhibits clear
    pulldown_en = ~mask_pd_inhibit & ~pulldown_inhibit_n & ~dir_bit_n;
    // Outputs read back what is driven, inputs the threshold level
    read_value = dir_bit_n ? drive_value : pin_in;
  end
endmodule

// ### hdl/pbl_port_low.sv
// APB-controlled pin logic for the five lowest lines of the second port
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/10ps

module pbl_port_low (
  input wire logic pclk, // System clock, 100 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction, high for write
  input wire logic [pbl_pkg::PBL_ADDR_W-1:0] paddr, // APB byte address
  input wire logic [pbl_pkg::PBL_DATA_W-1:0] pwdata, // APB write data
  output logic [pbl_pkg::PBL_DATA_W-1:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error for unmapped address
  input wire logic [pbl_pkg::PBL_LINES-1:0] port_in, // Pin levels after threshold
  output logic [pbl_pkg::PBL_LINES-1:0] port_out, // Pin output values
  output logic [pbl_pkg::PBL_LINES-1:0] port_oe, // Pin output enables
  output logic [pbl_pkg::PBL_LINES-1:0] pulldown_en, // Pulldown switch per pin
  input wire logic compare_output_level, // Timer compare level bit
  input wire logic comparator1_out, // Comparator 1 output
  input wire logic comparator1_out_enable, // Comparator 1 output enable bit
  input wire logic mask_comp_out, // Mask option allowing comparator drive
  input wire logic mask_pd_inhibit, // Mask option disabling all pulldowns
  output logic [pbl_pkg::PBL_LINES-2:0] analog_in_low, // Lines 0 to 3 to the analog module
  output logic analog_channel4 // Line 4 to analog multiplexer channel 4
);
  import pbl_pkg::*;

  logic [PBL_LINES-1:0] data_latch;
  logic [PBL_LINES-1:0] dir_reg_b;
  logic [PBL_LINES-1:0] pulldown_ctl_reg_b;
  logic [PBL_LINES-1:0] next_data_latch;
  logic [PBL_LINES-1:0] next_dir_reg_b;
  logic [PBL_LINES-1:0] next_pulldown_ctl_reg_b;
  logic [PBL_DATA_W-1:0] next_prdata;
  logic [PBL_LINES-1:0] drive_value;
  logic [PBL_LINES-1:0] read_value;
  logic line4_extra;
  logic setup_phase;
  logic write_access;

  // Decode of the mapped word addresses
  function automatic logic addr_mapped(input logic [PBL_ADDR_W-1:0] a);
    addr_mapped = (a == PBL_OFF_DATA) || (a == PBL_OFF_DIR) || (a == PBL_OFF_PDI);
  endfunction

  // Zero-wait slave; error flagged in the access phase only
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_mapped(paddr);
  assign setup_phase = psel & ~penable;
  assign write_access = psel & penable & pwrite;

  // Line 4 also takes the compare level and the gated comparator
  assign line4_extra = compare_output_level | (comparator1_out & comparator1_out_enable & mask_comp_out);
  always_comb begin
    drive_value = data_latch;
    drive_value[PBL_CMP_LINE] = data_latch[PBL_CMP_LINE] | line4_extra;
  end

  // Analog taps come straight off the pins, whatever the direction
  assign analog_in_low = port_in[PBL_LINES-2:0];
  assign analog_channel4 = port_in[PBL_CMP_LINE];

  // One cell per line
  for (genvar i = 0; i < PBL_LINES; i++) begin : g_line
    pbl_pin_cell u_cell (
      .drive_value(drive_value[i]),
      .dir_bit_n(dir_reg_b[i]),
      .pulldown_inhibit_n(pulldown_ctl_reg_b[i]),
      .mask_pd_inhibit(mask_pd_inhibit),
      .pin_in(port_in[i]),
      .pin_out(port_out[i]),
      .pin_oe(port_oe[i]),
      .pulldown_en(pulldown_en[i]),
      .read_value(read_value[i])
    );
  end

  // Next register values; writes land in the access phase only
  always_comb begin
    next_data_latch = data_latch;
    next_dir_reg_b = dir_reg_b;
    next_pulldown_ctl_reg_b = pulldown_ctl_reg_b;
    next_prdata = prdata;
    if (write_access && paddr == PBL_OFF_DATA) begin
      next_data_latch = pwdata[PBL_LINES-1:0];
    end else if (write_access && paddr == PBL_OFF_DIR) begin
      next_dir_reg_b = pwdata[PBL_LINES-1:0];
    end else if (write_access && paddr == PBL_OFF_PDI) begin
      next_pulldown_ctl_reg_b = pwdata[PBL_LINES-1:0];
    end
    // Read data is sampled in setup so it stands through the access
    if (setup_phase && !pwrite) begin
      next_prdata = PBL_ZERO_WORD;
      if (paddr == PBL_OFF_DATA) begin
        next_prdata[PBL_LINES-1:0] = read_value;
      end else if (paddr == PBL_OFF_DIR) begin
        next_prdata[PBL_LINES-1:0] = dir_reg_b;
      end
    end
  end

  // Register stage; data latch is cleared too so pins never float unknown
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_latch <= PBL_RST_DATA;
      dir_reg_b <= PBL_RST_DIR;
      pulldown_ctl_reg_b <= PBL_RST_PDI;
      prdata <= PBL_ZERO_WORD;
    end else begin
      data_latch <= next_data_latch;
      dir_reg_b <= next_dir_reg_b;
      pulldown_ctl_reg_b <= next_pulldown_ctl_reg_b;
      prdata <= next_prdata;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_dir_write;
    psel && !penable && pwrite && paddr == PBL_OFF_DIR ##1 psel && penable;
  endsequence

  sequence s_data_read_setup;
    psel && !penable && !pwrite && paddr == PBL_OFF_DATA;
  endsequence

  a_output_drives_latch: assert property (
    dir_reg_b[0] |-> port_oe[0] && !pulldown_en[0] && port_out[0] == data_latch[0])
    else $error("line 0 output not driven from latch");

  a_input_read_pin: assert property (
    s_data_read_setup and !dir_reg_b[1] |=> prdata[1] == $past(port_in[1]))
    else $error("input read did not return pin level");

  a_line4_or_drive: assert property (
    port_out[4] == (data_latch[4] | compare_output_level
      | (comparator1_out & comparator1_out_enable & mask_comp_out)))
    else $error("line 4 drive is not the OR of its sources");

  a_analog_ch4_tap: assert property (
    analog_channel4 == port_in[4])
    else $error("analog channel 4 not tied to line 4");

  a_line4_input_pd: assert property (
    !dir_reg_b[4] && pulldown_ctl_reg_b[4] |-> !port_oe[4] && !pulldown_en[4])
    else $error("line 4 input with inhibit still pulled down");

  a_dir_write_read: assert property (
    s_dir_write ##1 !psel ##1 psel && !penable && !pwrite && paddr == PBL_OFF_DIR
      |=> prdata[PBL_LINES-1:0] == $past(pwdata[PBL_LINES-1:0], 4))
    else $error("direction write not read back");

  a_output_read_latch: assert property (
    s_data_read_setup and dir_reg_b[2] |=> prdata[2] == $past(data_latch[2]))
    else $error("output read did not return latch");

  a_latch_write_any: assert property (
    write_access && paddr == PBL_OFF_DATA |=> data_latch == $past(pwdata[PBL_LINES-1:0]))
    else $error("data latch write lost");

  a_pulldown_equation: assert property (
    pulldown_en == (~dir_reg_b & ~pulldown_ctl_reg_b & {PBL_LINES{~mask_pd_inhibit}}))
    else $error("pulldown state wrong");

  a_reset_dir_clear: assert property (
    $rose(presetn) |-> dir_reg_b == PBL_RST_DIR && port_oe == PBL_RST_DIR)
    else $error("direction not cleared by reset");

  // Output buffers track the direction register bit for bit
  a_oe_follows_dir: assert property (
    port_oe == dir_reg_b)
    else $error("output enable differs from direction");

  a_out_pd_off: assert property (
    (pulldown_en & dir_reg_b) == '0)
    else $error("pulldown on for an output line");

  a_low_out_latch: assert property (
    port_out[PBL_LINES-2:0] == data_latch[PBL_LINES-2:0])
    else $error("low lines not driven from latch");

  // The shared module sees the pins, so a driven line can fight it
  a_analog_low_tap: assert property (
    analog_in_low == port_in[PBL_LINES-2:0])
    else $error("analog taps not tied to low lines");

  // Line 4 set-ups: each source alone must reach the pin
  a_level_mode_out: assert property (
    dir_reg_b[PBL_CMP_LINE] && !data_latch[PBL_CMP_LINE] && !(comparator1_out_enable && mask_comp_out)
      |-> port_out[PBL_CMP_LINE] == compare_output_level && !pulldown_en[PBL_CMP_LINE])
    else $error("line 4 does not follow the compare level");

  a_data_mode_out: assert property (
    dir_reg_b[PBL_CMP_LINE] && !compare_output_level && !(comparator1_out_enable && mask_comp_out)
      |-> port_out[PBL_CMP_LINE] == data_latch[PBL_CMP_LINE] && !pulldown_en[PBL_CMP_LINE])
    else $error("line 4 does not follow the data bit");

  a_comp_mode_out: assert property (
    dir_reg_b[PBL_CMP_LINE] && !data_latch[PBL_CMP_LINE] && !compare_output_level
      && comparator1_out_enable && mask_comp_out
      |-> port_out[PBL_CMP_LINE] == comparator1_out && !pulldown_en[PBL_CMP_LINE])
    else $error("line 4 does not follow the comparator");

  // Line 4 read-back: pin level as input, driven OR value as output
  a_line4_read_pin: assert property (
    s_data_read_setup and !dir_reg_b[PBL_CMP_LINE] |=> prdata[PBL_CMP_LINE] == $past(port_in[PBL_CMP_LINE]))
    else $error("line 4 input read did not return pin level");

  a_line4_read_or: assert property (
    s_data_read_setup and dir_reg_b[PBL_CMP_LINE] |=> prdata[PBL_CMP_LINE] == $past(port_out[PBL_CMP_LINE]))
    else $error("line 4 output read did not return driven value");

  // Direction reads never depend on pin function
  a_dir_read_any: assert property (
    psel && !penable && !pwrite && paddr == PBL_OFF_DIR
      |=> prdata[PBL_LINES-1:0] == $past(dir_reg_b) && prdata[PBL_DATA_W-1:PBL_LINES] == '0)
    else $error("direction read wrong");

  a_dir_write_lands: assert property (
    write_access && paddr == PBL_OFF_DIR |=> dir_reg_b == $past(pwdata[PBL_LINES-1:0]))
    else $error("direction write lost");

  a_pdi_write_lands: assert property (
    write_access && paddr == PBL_OFF_PDI |=> pulldown_ctl_reg_b == $past(pwdata[PBL_LINES-1:0]))
    else $error("pulldown inhibit write lost");
endmodule

// ### sim/pbl_pin_ext.sv
// Model of the outside circuitry on the five low port lines
`timescale 1ns/10ps

module pbl_pin_ext (
  input wire logic pclk, // System clock
  input wire logic [4:0] port_out, // Device drive values
  input wire logic [4:0] port_oe, // Device drive enables
  input wire logic [4:0] pulldown_en, // Device pulldowns
  input wire logic [4:0] ext_val, // Outside source value
  input wire logic [4:0] ext_en, // Outside source enable
  output logic [4:0] port_in // Thresholded pin level
);
  logic [4:0] last_lvl = 5'h00;
  // Outside source wins a clash; an unheld line wanders, never holds its level
  assign port_in = (ext_en & ext_val) | (~ext_en & port_oe & port_out)
    | (~ext_en & ~port_oe & ~pulldown_en & ~last_lvl);
  // Memory of the level, only to make floating lines move
  always @(posedge pclk) begin
    last_lvl <= port_in;
  end
endmodule

// ### sim/tb_port_b_low_pin_logic.sv
// Self-checking bench for the low port line logic
`timescale 1ns/10ps

module tb_port_b_low_pin_logic;
  import pbl_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [4:0] port_in, port_out, port_oe, pulldown_en, ext_val = 5'h00, ext_en = 5'h00;
  logic compare_output_level = 0, comparator1_out = 0, comparator1_out_enable = 0;
  logic mask_comp_out = 1, mask_pd_inhibit = 0, analog_channel4, e;
  logic [3:0] analog_in_low;
  int fail_count = 0, tests_run = 0;
  // Free-running system clock
  always #5 pclk = ~pclk;
  pbl_port_low dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .port_in, .port_out, .port_oe, .pulldown_en, .compare_output_level, .comparator1_out,
    .comparator1_out_enable, .mask_comp_out, .mask_pd_inhibit, .analog_in_low, .analog_channel4);
  pbl_pin_ext ext (.pclk, .port_out, .port_oe, .pulldown_en, .ext_val, .ext_en, .port_in);
  task summarize;
    if (fail_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  // One APB transfer, then one idle edge so pin outputs settle
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task t_reset;
    chk(32'(port_oe), 32'h0);
    chk(32'(pulldown_en), 32'h1F);
    apb(0, PBL_OFF_DIR, 32'h0);
    chk(rd, 32'h0);
  endtask
  // Outputs on lines 0 to 3 fighting an outside source
  task t_out;
    ext_en <= 5'h1F;
    ext_val <= 5'h15;
    apb(1, PBL_OFF_DATA, 32'h0000000A);
    apb(1, PBL_OFF_DIR, 32'h0000000F);
    apb(0, PBL_OFF_DIR, 32'h0);
    chk(rd, 32'h0F);
    chk(32'(port_oe), 32'h0F);
    chk(32'(port_out[3:0]), 32'hA);
    chk(32'(pulldown_en), 32'h10);
    chk(32'(analog_in_low), 32'h5);
    apb(0, PBL_OFF_DATA, 32'h0);
    chk(rd, 32'h1A);
  endtask
  // Every mix of latch, compare level, comparator and its enable on line 4
  task t_line4;
    ext_en <= 5'h00;
    apb(1, PBL_OFF_DIR, 32'h10);
    for (int k = 0; k < 16; k++) begin
      compare_output_level <= k[1];
      comparator1_out <= k[2];
      comparator1_out_enable <= k[3];
      apb(1, PBL_OFF_DATA, {27'h0, k[0], 4'h0});
      e = k[0] | k[1] | (k[2] & k[3]);
      chk(32'(port_out[4]), 32'(e));
      chk(32'(analog_channel4), 32'(e));
      apb(0, PBL_OFF_DATA, 32'h0);
      chk(32'(rd[4]), 32'(e));
    end
  endtask
  // Line 4 in each software set-up; comparator blocked while its option is off
  task t_fn;
    ext_en <= 5'h00;
    mask_comp_out <= 0;
    comparator1_out <= 1;
    comparator1_out_enable <= 1;
    compare_output_level <= 1;
    apb(1, PBL_OFF_DIR, 32'h10);
    apb(1, PBL_OFF_DATA, 32'h0);
    chk(32'(port_out[4]), 32'h1);
    chk(32'(pulldown_en[4]), 32'h0);
    compare_output_level <= 0;
    @(posedge pclk);
    chk(32'(port_out[4]), 32'h0);
    apb(1, PBL_OFF_DATA, 32'h10);
    chk(32'(port_out[4]), 32'h1);
    apb(1, PBL_OFF_DATA, 32'h0);
    chk(32'(port_out[4]), 32'h0);
    mask_comp_out <= 1;
    @(posedge pclk);
    chk(32'(port_out[4]), 32'h1);
    chk(32'(pulldown_en[4]), 32'h0);
    comparator1_out <= 0;
    @(posedge pclk);
    chk(32'(port_out[4]), 32'h0);
  endtask
  // Pulldown inhibit bits, mask option and an unmapped access
  task t_pd;
    ext_en <= 5'h1F;
    ext_val <= 5'h10;
    apb(1, PBL_OFF_DIR, 32'h0);
    apb(1, PBL_OFF_PDI, 32'h13);
    chk(32'(pulldown_en), 32'h0C);
    apb(0, PBL_OFF_DATA, 32'h0);
    chk(rd, 32'h10);
    mask_pd_inhibit <= 1;
    apb(1, 8'h0C, 32'h1F);
    chk(32'(err), 32'h1);
    chk(32'(pulldown_en), 32'h0);
  endtask
  // Reset in mid-run drops every output and pulldown inhibit again
  task t_rst2;
    mask_pd_inhibit <= 0;
    apb(1, PBL_OFF_DIR, 32'h1F);
    chk(32'(port_oe), 32'h1F);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk(32'(port_oe), 32'h0);
    chk(32'(pulldown_en), 32'h1F);
    apb(0, PBL_OFF_DIR, 32'h0);
    chk(rd, 32'h0);
  endtask
  // Reset held six edges, then the scenarios in turn
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_reset();
    t_out();
    t_line4();
    t_fn();
    t_pd();
    t_rst2();
    summarize();
  end
endmodule
